// *** core/ued_top.sv ***
// Functional notes
// - Setting the enable bit snapshots endpoint config, interface map and both base pointers.
// - Clearing the enable bit resets the USB logic back to its powered state.
// - The enable bit is read/write, 1 enabled, 0 disabled, cleared by reset.
// - The clock gate bit lets the USB clock reach the module, blocked while it is zero.
// - The clock gate bit is read/write, 1 clock on, 0 clock off, cleared by reset.
// - Device reset leaves the eight endpoint-0 data bytes unchanged.
// - IN tokens get NAK until software has loaded bytes and count and set the valid bit.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module ued_top import ued_pkg::*; (
  input wire logic core_clk_i, // Core clock, 25 MHz.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [APB_AW-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped index.
  output logic usb_clk_on_o, // Gate enable for the 48MHz USB clock.
  output logic usb_active_o, // USB logic enabled and clocked.
  output logic [4*BASE_W-1:0] work_base_o, // Working base fields, ep4..ep1.
  output logic [7:0] work_intf_o, // Working endpoint interface map.
  output logic [7:0] work_ep_cfg_o, // Working endpoint config.
  input wire logic in_token_i, // Endpoint-0 IN token seen, one-cycle pulse.
  input wire logic in_ack_i, // Host ACKed the IN packet, one-cycle pulse.
  output logic in_nak_o, // Answer NAK to the token, one-cycle pulse.
  output logic tx_valid_o, // IN byte available.
  input wire logic tx_ready_i, // Link takes the IN byte.
  output logic [7:0] tx_data_o, // IN byte.
  output logic tx_last_o, // Last byte of the IN packet.
  input wire logic rx_valid_i, // OUT byte offered.
  output logic rx_ready_o, // OUT byte accepted.
  input wire logic [7:0] rx_data_i, // OUT byte.
  input wire logic rx_last_i // Last byte of the OUT packet.
);

  localparam int unsigned IW = $clog2(EP0_BYTES);

  // ************************************************************
  // Decoding helpers.
  // ************************************************************
  // Maps a register index to a data byte slot; bit IW flags a hit.
  function automatic logic [IW:0] data_slot(input logic [7:0] idx);
    case (idx)
      IDX_EP0_DATA0: data_slot = {1'b1, IW'(0)};
      IDX_EP0_DATA1: data_slot = {1'b1, IW'(1)};
      IDX_EP0_DATA2: data_slot = {1'b1, IW'(2)};
      IDX_EP0_DATA3: data_slot = {1'b1, IW'(3)};
      IDX_EP0_DATA4: data_slot = {1'b1, IW'(4)};
      IDX_EP0_DATA5: data_slot = {1'b1, IW'(5)};
      IDX_EP0_DATA6: data_slot = {1'b1, IW'(6)};
      IDX_EP0_DATA7: data_slot = {1'b1, IW'(7)};
      default: data_slot = '0;
    endcase
  endfunction

  logic enable_reg;
  logic clk_gate_reg;
  logic [7:0] ep12_reg;
  logic [7:0] ep34_reg;
  logic [7:0] intf_reg;
  logic [7:0] ep_cfg_reg;
  logic [CNT_W-1:0] in_cnt_reg;
  logic [CNT_W-1:0] out_cnt_reg;
  logic valid_reg;
  logic [7:0] w_ep12_reg;
  logic [7:0] w_ep34_reg;
  logic [7:0] w_intf_reg;
  logic [7:0] w_cfg_reg;
  logic [31:0] prdata_reg;
  ued_in_state_t state_reg;
  ued_in_state_t state_next;
  logic [IW:0] tx_idx_reg;
  logic [IW-1:0] rx_idx_reg;
  logic nak_reg;

  // ************************************************************
  // APB decode.
  // ************************************************************
  // Zero-wait slave: read data is captured in the setup cycle.
  logic [7:0] idx;
  logic [IW:0] slot;
  logic mapped;
  logic setup;
  logic wr_en;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  logic [7:0] buf_rdata;
  logic active;
  logic soft_rst;
  logic enable_rise;
  logic ack_clr;
  logic sw_valid_wr;
  assign idx = paddr[IDX_LSB +: 8];
  assign slot = data_slot(idx);
  assign mapped = slot[IW] || (idx == IDX_MODULE_CTRL) || (idx == IDX_EP0_CTRL)
    || (idx == IDX_EP_CFG) || (idx == IDX_EP12_BASE) || (idx == IDX_EP34_BASE)
    || (idx == IDX_INTF_MAP);
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign pslverr = pready && !mapped;
  assign wr_en = pready && pwrite && mapped;
  assign wb = pwdata[7:0];
  assign prdata = prdata_reg;

  // Read mux; unused bits of every register read as zero.
  assign rd_byte = slot[IW] ? buf_rdata :
    (idx == IDX_MODULE_CTRL) ? 8'((enable_reg << BIT_MODULE_ENABLE)
      | (clk_gate_reg << BIT_CLOCK_GATE)) :
    (idx == IDX_EP0_CTRL) ? 8'((out_cnt_reg << CNT_LSB) | (valid_reg << BIT_PACKET_VALID)) :
    (idx == IDX_EP_CFG) ? ep_cfg_reg :
    (idx == IDX_EP12_BASE) ? ep12_reg :
    (idx == IDX_EP34_BASE) ? ep34_reg :
    (idx == IDX_INTF_MAP) ? intf_reg : REG_RESET;

  // ************************************************************
  // Module control.
  // ************************************************************
  // The USB side runs only when both the gate and the enable are set.
  assign active = enable_reg && clk_gate_reg;
  assign soft_rst = !enable_reg;
  assign usb_clk_on_o = clk_gate_reg;
  assign usb_active_o = active;
  assign enable_rise = wr_en && (idx == IDX_MODULE_CTRL) && wb[BIT_MODULE_ENABLE]
    && !enable_reg;
  assign ack_clr = (state_reg == UED_WAIT_ACK) && in_ack_i && active;
  assign sw_valid_wr = wr_en && (idx == IDX_EP0_CTRL);

  // Software registers; reset clears enable and gate.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_reg <= 1'b0;
      clk_gate_reg <= 1'b0;
      ep12_reg <= REG_RESET;
      ep34_reg <= REG_RESET;
      intf_reg <= REG_RESET;
      ep_cfg_reg <= REG_RESET;
      prdata_reg <= '0;
    end else begin
      if (setup) begin
        prdata_reg <= {24'h0000_00, rd_byte};
      end
      if (wr_en && (idx == IDX_MODULE_CTRL)) begin
        enable_reg <= wb[BIT_MODULE_ENABLE];
        clk_gate_reg <= wb[BIT_CLOCK_GATE];
      end
      if (wr_en && (idx == IDX_EP12_BASE)) begin
        ep12_reg <= wb & BASE_MASK;
      end
      if (wr_en && (idx == IDX_EP34_BASE)) begin
        ep34_reg <= wb & BASE_MASK;
      end
      if (wr_en && (idx == IDX_INTF_MAP)) begin
        intf_reg <= wb & INTF_MASK;
      end
      if (wr_en && (idx == IDX_EP_CFG)) begin
        ep_cfg_reg <= wb;
      end
    end
  end

  // Working copy is taken only on the enable edge, so later writes wait.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_ep12_reg <= REG_RESET;
      w_ep34_reg <= REG_RESET;
      w_intf_reg <= REG_RESET;
      w_cfg_reg <= REG_RESET;
    end else if (enable_rise) begin
      w_ep12_reg <= ep12_reg;
      w_ep34_reg <= ep34_reg;
      w_intf_reg <= intf_reg;
      w_cfg_reg <= ep_cfg_reg;
    end
  end

  assign work_base_o = {w_ep34_reg[BASE_HI_LSB +: BASE_W], w_ep34_reg[BASE_W-1:0],
    w_ep12_reg[BASE_HI_LSB +: BASE_W], w_ep12_reg[BASE_W-1:0]};
  assign work_intf_o = w_intf_reg;
  assign work_ep_cfg_o = w_cfg_reg;

  // ************************************************************
  // Endpoint-0 control: IN count, valid bit, OUT count.
  // ************************************************************
  // A software set in the same cycle as the ACK clear wins.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else if (soft_rst) begin
      in_cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else if (sw_valid_wr) begin
      in_cnt_reg <= wb[CNT_LSB +: CNT_W];
      valid_reg <= wb[BIT_PACKET_VALID];
    end else if (ack_clr) begin
      valid_reg <= 1'b0;
    end
  end

  // ************************************************************
  // IN packet sequencer.
  // ************************************************************
  // A full FIFO stalls the sender without losing its place.
  logic fifo_in_ready;
  logic last_byte;
  logic push;
  logic [7:0] tx_byte;
  assign last_byte = (tx_idx_reg + 1'b1) == (IW+1)'(in_cnt_reg);
  assign push = (state_reg == UED_SEND) && fifo_in_ready;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      UED_IDLE: begin
        if (in_token_i && active && valid_reg) begin
          state_next = (in_cnt_reg == '0) ? UED_WAIT_ACK : UED_SEND;
        end
      end
      UED_SEND: begin
        if (push && last_byte) begin
          state_next = UED_WAIT_ACK;
        end
      end
      UED_WAIT_ACK: begin
        if (in_ack_i) begin
          state_next = UED_IDLE;
        end
      end
      default: state_next = UED_IDLE;
    endcase
  end

  // State, byte index and NAK pulse.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= UED_IDLE;
      tx_idx_reg <= '0;
      nak_reg <= 1'b0;
    end else if (!active) begin
      state_reg <= UED_IDLE;
      tx_idx_reg <= '0;
      nak_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tx_idx_reg <= (state_next == UED_SEND) ? tx_idx_reg + (IW+1)'(push) : '0;
      nak_reg <= in_token_i && (state_reg == UED_IDLE) && !valid_reg;
    end
  end
  assign in_nak_o = nak_reg;

  ued_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) ued_fifo_i (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .flush_i(!active),
    .in_valid_i(state_reg == UED_SEND),
    .in_ready_o(fifo_in_ready),
    .in_data_i({last_byte, tx_byte}),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o({tx_last_o, tx_data_o})
  );

  // ************************************************************
  // OUT packet capture.
  // ************************************************************
  // Bytes past the eighth are accepted and each one overwrites the eighth byte.
  assign rx_ready_o = active;
  logic rx_take;
  assign rx_take = rx_valid_i && active;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_idx_reg <= '0;
      out_cnt_reg <= '0;
    end else if (soft_rst) begin
      rx_idx_reg <= '0;
      out_cnt_reg <= '0;
    end else if (rx_take && rx_last_i) begin
      rx_idx_reg <= '0;
      out_cnt_reg <= CNT_W'(rx_idx_reg) + 1'b1;
    end else if (rx_take && (rx_idx_reg != IW'(EP0_BYTES - 1))) begin
      rx_idx_reg <= rx_idx_reg + 1'b1;
    end
  end

  ued_ep0_buf #(.NBYTES(EP0_BYTES)) ued_ep0_buf_i (
    .core_clk_i(core_clk_i),
    .cpu_we_i(wr_en && slot[IW]),
    .cpu_idx_i(slot[IW-1:0]),
    .cpu_wdata_i(wb),
    .cpu_rdata_o(buf_rdata),
    .link_we_i(rx_take),
    .link_idx_i(rx_idx_reg),
    .link_wdata_i(rx_data_i),
    .tx_idx_i(tx_idx_reg[IW-1:0]),
    .tx_data_o(tx_byte)
  );

  // ************************************************************
  // Checks.
  // ************************************************************
  sequence s_token_unarmed;
    in_token_i && active && !valid_reg && (state_reg == UED_IDLE);
  endsequence

  AST_NAK_WHEN_UNARMED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_token_unarmed |=> in_nak_o) else $error("no nak on unarmed token");
  AST_NO_SEND_UNARMED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (state_reg == UED_IDLE) && !valid_reg |=> state_reg == UED_IDLE)
    else $error("send started without valid");
  AST_ENABLE_CLEAR_RESETS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !enable_reg |=> !valid_reg && (state_reg == UED_IDLE))
    else $error("disabled module kept state");
  AST_SNAPSHOT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    enable_rise |=> (w_ep12_reg == $past(ep12_reg)) && (w_intf_reg == $past(intf_reg)))
    else $error("working config not loaded on enable");
  AST_SNAPSHOT_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !enable_rise |=> $stable(w_ep34_reg) && $stable(w_cfg_reg))
    else $error("working config changed without enable");
  AST_GATE_BLOCKS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !clk_gate_reg |-> !usb_active_o && !rx_ready_o && !usb_clk_on_o)
    else $error("usb logic running with gate off");
  AST_CTRL_READBACK: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_en && (idx == IDX_MODULE_CTRL) |=> (enable_reg == $past(wb[BIT_MODULE_ENABLE]))
    && (clk_gate_reg == $past(wb[BIT_CLOCK_GATE])))
    else $error("control bits not written");
  AST_BASE_MASKED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ((ep12_reg & ~BASE_MASK) == 8'h00) && ((ep34_reg & ~BASE_MASK) == 8'h00))
    else $error("reserved base bits set");
  AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ack_clr && sw_valid_wr && wb[BIT_PACKET_VALID] && enable_reg |=> valid_reg)
    else $error("software set lost to ack clear");

endmodule

// *** core/ued_pkg.sv ***
package ued_pkg;

  // ************************************************************
  // Register indices; the byte address is four times the index.
  // ************************************************************
  localparam int unsigned APB_AW = 10;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [7:0] IDX_EP0_DATA0 = 8'h40;
  localparam logic [7:0] IDX_EP0_DATA1 = 8'h41;
  localparam logic [7:0] IDX_EP0_DATA2 = 8'h42;
  localparam logic [7:0] IDX_EP0_DATA3 = 8'h43;
  localparam logic [7:0] IDX_EP0_DATA5 = 8'h44;
  localparam logic [7:0] IDX_EP0_DATA6 = 8'h45;
  localparam logic [7:0] IDX_EP0_DATA7 = 8'h46;
  localparam logic [7:0] IDX_EP0_DATA4 = 8'h47;
  localparam logic [7:0] IDX_MODULE_CTRL = 8'h51;
  localparam logic [7:0] IDX_EP0_CTRL = 8'h54;
  localparam logic [7:0] IDX_EP_CFG = 8'h55;
  localparam logic [7:0] IDX_EP12_BASE = 8'h5d;
  localparam logic [7:0] IDX_EP34_BASE = 8'h5e;
  localparam logic [7:0] IDX_INTF_MAP = 8'h5f;

  // ************************************************************
  // Field layout and reset values.
  // ************************************************************
  localparam int unsigned BIT_MODULE_ENABLE = 7;
  localparam int unsigned BIT_CLOCK_GATE = 6;
  localparam int unsigned BIT_PACKET_VALID = 3;
  localparam int unsigned CNT_LSB = 4;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned EP0_BYTES = 8;
  localparam int unsigned BASE_W = 3;
  localparam int unsigned BASE_HI_LSB = 4;
  localparam logic [7:0] BASE_MASK = 8'h77;
  localparam logic [7:0] INTF_MASK = 8'h55;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned CLK_MHZ = 25;

  typedef enum logic [1:0] {
    UED_IDLE,
    UED_SEND,
    UED_WAIT_ACK
  } ued_in_state_t;

endpackage

// *** core/ued_fifo.sv ***
`timescale 1ns/1ps
module ued_fifo import ued_pkg::*; #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk_i, // Core clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic flush_i, // Synchronous flush.
  input wire logic in_valid_i, // Word offered.
  output logic in_ready_o, // Room for a word.
  input wire logic [WIDTH-1:0] in_data_i, // Word to store.
  output logic out_valid_o, // Word available.
  input wire logic out_ready_i, // Drain side takes the word.
  output logic [WIDTH-1:0] out_data_o // Oldest word.
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  // ************************************************************
  // Handshake.
  // ************************************************************
  // Full and empty come straight from the occupancy count.
  assign in_ready_o = (cnt_reg != (PW+1)'(DEPTH)) && !flush_i;
  assign out_valid_o = (cnt_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_reg];

  // Storage has no reset; only pointers matter.
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  // Pointers wrap at the depth; depth is a power of two.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (flush_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_reg + PW'(push);
      rd_reg <= rd_reg + PW'(pop);
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cnt_reg <= (PW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

// *** core/ued_ep0_buf.sv ***
`timescale 1ns/1ps
module ued_ep0_buf import ued_pkg::*; #(
  parameter int unsigned NBYTES = EP0_BYTES
) (
  input wire logic core_clk_i, // Core clock.
  input wire logic cpu_we_i, // Software writes an IN byte.
  input wire logic [$clog2(NBYTES)-1:0] cpu_idx_i, // Byte selected by software.
  input wire logic [7:0] cpu_wdata_i, // IN byte value.
  output logic [7:0] cpu_rdata_o, // OUT byte at the selected index.
  input wire logic link_we_i, // Link stores a received OUT byte.
  input wire logic [$clog2(NBYTES)-1:0] link_idx_i, // OUT byte position.
  input wire logic [7:0] link_wdata_i, // Received OUT byte.
  input wire logic [$clog2(NBYTES)-1:0] tx_idx_i, // IN byte to send.
  output logic [7:0] tx_data_o // IN byte for the link.
);

  logic [7:0] out_reg [NBYTES];
  logic [7:0] in_reg [NBYTES];

  // ************************************************************
  // Byte storage, two banks behind one address each.
  // ************************************************************
  // No reset on purpose: contents survive any device reset.
  for (genvar g = 0; g < NBYTES; g++) begin : g_byte
    always_ff @(posedge core_clk_i) begin
      if (link_we_i && (link_idx_i == g)) begin
        out_reg[g] <= link_wdata_i;
      end
      if (cpu_we_i && (cpu_idx_i == g)) begin
        in_reg[g] <= cpu_wdata_i;
      end
    end
  end

  // Reads see the OUT bank; the link sends from the IN bank.
  assign cpu_rdata_o = out_reg[cpu_idx_i];
  assign tx_data_o = in_reg[tx_idx_i];

endmodule

// *** test/ued_host_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Behavioural USB host standing across the endpoint-0 link.
// ************************************************************
module ued_host_model (
  input wire logic core_clk_i, // Core clock.
  output logic in_token_o, // IN token pulse.
  output logic in_ack_o, // ACK pulse.
  input wire logic in_nak_i, // NAK answer.
  input wire logic tx_valid_i, // IN byte offered.
  output logic tx_ready_o, // IN byte taken.
  input wire logic [7:0] tx_data_i, // IN byte.
  input wire logic tx_last_i, // Last IN byte.
  output logic rx_valid_o, // OUT byte offered.
  input wire logic rx_ready_i, // OUT byte accepted.
  output logic [7:0] rx_data_o, // OUT byte.
  output logic rx_last_o // Last OUT byte.
);
  logic slow;
  logic [7:0] got[$];
  int naks;
  int lasts;

  // Quiet outputs at time zero.
  initial begin
    {in_token_o, in_ack_o, tx_ready_o, rx_valid_o, rx_last_o, slow} = '0;
    rx_data_o = 8'h00;
    naks = 0;
    lasts = 0;
  end

  // A slow host stalls every other cycle, so the IN FIFO backs up.
  always @(posedge core_clk_i) begin
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
      got.push_back(tx_data_i);
      if (tx_last_i === 1'b1) lasts++;
    end
    if (in_nak_i === 1'b1) naks++;
  end

  task automatic pulse_token();
    @(posedge core_clk_i);
    in_token_o <= 1'b1;
    @(posedge core_clk_i);
    in_token_o <= 1'b0;
  endtask

  task automatic pulse_ack();
    @(posedge core_clk_i);
    in_ack_o <= 1'b1;
    @(posedge core_clk_i);
    in_ack_o <= 1'b0;
  endtask

  // Bytes go back to back; a released data line shows the inverse.
  task automatic out_pkt(input int n, input logic [7:0] b);
    int k;
    @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= b + 8'(i);
      rx_last_o <= (i == n - 1);
      k = 0;
      do begin
        @(posedge core_clk_i);
        k++;
      end while (rx_ready_i !== 1'b1 && k < 50);
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule

// *** test/ued_top_tb_top.sv ***
`timescale 1ns/1ps
module ued_top_tb_top import ued_pkg::*;;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, usb_clk_on_o, usb_active_o, in_token, in_ack, in_nak;
  logic tx_valid, tx_ready, tx_last, rx_valid, rx_ready, rx_last;
  logic [7:0] tx_data, rx_data, work_intf_o, work_ep_cfg_o;
  logic [4*BASE_W-1:0] work_base_o;
  int n_fail = 0;
  int checks_done = 0;
  logic [7:0] didx [8] = '{IDX_EP0_DATA0, IDX_EP0_DATA1, IDX_EP0_DATA2, IDX_EP0_DATA3,
                           IDX_EP0_DATA4, IDX_EP0_DATA5, IDX_EP0_DATA6, IDX_EP0_DATA7};

  // 25 MHz core clock.
  always #20 core_clk_i = ~core_clk_i;

  ued_top ued_top_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_clk_on_o(usb_clk_on_o),
    .usb_active_o(usb_active_o), .work_base_o(work_base_o), .work_intf_o(work_intf_o),
    .work_ep_cfg_o(work_ep_cfg_o), .in_token_i(in_token), .in_ack_i(in_ack),
    .in_nak_o(in_nak), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
    .tx_last_o(tx_last), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .rx_data_i(rx_data), .rx_last_i(rx_last));

  ued_host_model host (.core_clk_i(core_clk_i), .in_token_o(in_token), .in_ack_o(in_ack),
    .in_nak_i(in_nak), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data),
    .tx_last_i(tx_last), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_data_o(rx_data), .rx_last_o(rx_last));

  // ************************************************************
  // Comparison and APB helpers.
  // ************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // The request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (!(psel === 1'b1 && penable === 1'b1 && pready === 1'b1) && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, {24'h00_0000, d}, r, e);
    chk({31'h0, e}, 32'h0000_0000);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, r, e);
    chk(r, {24'h00_0000, x});
    chk({31'h0, e}, 32'h0000_0000);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    wrap_up();
  end

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(IDX_MODULE_CTRL, 8'h00);
    rd(IDX_EP12_BASE, 8'h00);
    rd(IDX_INTF_MAP, 8'h00);
    apb(1'b0, 8'h00, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    $display("test reset_values done");
    wr(IDX_MODULE_CTRL, 8'h40);
    rd(IDX_MODULE_CTRL, 8'h40);
    chk({30'h0, usb_clk_on_o, usb_active_o}, 32'h0000_0002);
    wr(IDX_EP12_BASE, 8'hb5);
    wr(IDX_EP34_BASE, 8'he1);
    wr(IDX_INTF_MAP, 8'hff);
    wr(IDX_EP_CFG, 8'ha5);
    rd(IDX_EP12_BASE, 8'h35);
    rd(IDX_EP34_BASE, 8'h61);
    rd(IDX_INTF_MAP, 8'h55);
    chk({20'h0, work_base_o}, 32'h0000_0000);
    wr(IDX_MODULE_CTRL, 8'hc0);
    rd(IDX_MODULE_CTRL, 8'hc0);
    chk({20'h0, work_base_o}, 32'h0000_0c5d);
    chk({16'h0, work_intf_o, work_ep_cfg_o}, 32'h0000_55a5);
    chk({31'h0, usb_active_o}, 32'h0000_0001);
    wr(IDX_EP12_BASE, 8'h00);
    chk({20'h0, work_base_o}, 32'h0000_0c5d);
    $display("test enable_snapshot done");
    host.pulse_token();
    repeat (3) @(posedge core_clk_i);
    chk(host.naks, 1);
    for (int i = 0; i < 8; i++) wr(didx[i], 8'h10 + 8'(i));
    host.slow = 1'b1;
    wr(IDX_EP0_CTRL, 8'h88);
    rd(IDX_EP0_CTRL, 8'h08);
    host.pulse_token();
    n = 0;
    while (host.lasts == 0 && n < 200) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(host.got.size(), 8);
    for (int i = 0; i < 8; i++) chk(host.got[i], 8'h10 + 8'(i));
    chk(host.naks, 1);
    host.pulse_ack();
    rd(IDX_EP0_CTRL, 8'h00);
    wr(IDX_EP0_CTRL, 8'h08);
    host.pulse_token();
    // The ACK is lined up with the access edge of the valid write.
    fork
      begin
        @(posedge core_clk_i);
        host.pulse_ack();
      end
      wr(IDX_EP0_CTRL, 8'h08);
    join
    rd(IDX_EP0_CTRL, 8'h08);
    chk(host.got.size(), 8);
    wr(IDX_EP0_CTRL, 8'h00);
    host.pulse_token();
    repeat (3) @(posedge core_clk_i);
    chk(host.naks, 2);
    $display("test in_transfer done");
    host.out_pkt(3, 8'ha0);
    for (int i = 0; i < 3; i++) rd(didx[i], 8'ha0 + 8'(i));
    rd(IDX_EP0_CTRL, 8'h30);
    $display("test out_transfer done");
    wr(IDX_MODULE_CTRL, 8'h80);
    rd(IDX_MODULE_CTRL, 8'h80);
    chk({30'h0, usb_clk_on_o, usb_active_o}, 32'h0000_0000);
    wr(IDX_MODULE_CTRL, 8'h00);
    rd(IDX_EP0_CTRL, 8'h00);
    host.pulse_token();
    repeat (3) @(posedge core_clk_i);
    chk(host.naks, 2);
    $display("test disable done");
    wr(IDX_MODULE_CTRL, 8'hc0);
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(IDX_MODULE_CTRL, 8'h00);
    for (int i = 0; i < 3; i++) rd(didx[i], 8'ha0 + 8'(i));
    $display("test device_reset done");
    wrap_up();
  end
endmodule
